// file: logic/cpw_duty.sv
// double-buffered duty latch, time base compare and output latch
`timescale 1ns/1ps
module cpw_duty (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // control
    input wire logic active,
    input wire logic sleep,
    input wire logic [9:0] duty_value,
    cpw_tb_if.dst tb,
    // results
    output logic level,
    output logic clear_event
);
    logic [9:0] buf_q;
    logic level_q;

    wire hit = (tb.time_base == buf_q);
    wire clear_now = active && !sleep && !tb.period_start && hit && level_q;

    // active copy changes only at the period start
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            buf_q <= 10'h000;
        end else if (active && !sleep && tb.period_start) begin
            buf_q <= duty_value;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            level_q <= 1'b0;
        end else if (!active) begin
            level_q <= 1'b0;
        end else if (sleep) begin
            level_q <= level_q;
        end else if (tb.period_start) begin
            level_q <= (duty_value != 10'h000);
        end else if (clear_now) begin
            level_q <= 1'b0;
        end
    end

    assign level = level_q;
    assign clear_event = clear_now;
endmodule

// file: logic/cpw_pkg.sv
// package: register map, field layout, reset values and modes of the pwm unit
package cpw_pkg;

    // register offsets on the 3-bit register port
    localparam logic [2:0] OFS_UNIT_CONTROL = 3'h0;
    localparam logic [2:0] OFS_CAPTURE_SOURCE_SELECT = 3'h1;
    localparam logic [2:0] OFS_DUTY_LOW = 3'h2;
    localparam logic [2:0] OFS_DUTY_HIGH = 3'h3;
    localparam logic [2:0] OFS_PERIOD_LIMIT = 3'h4;
    localparam logic [2:0] OFS_TIMER_CONTROL = 3'h5;
    localparam logic [2:0] OFS_TIMER_COUNT = 3'h6;
    localparam logic [2:0] OFS_STATUS = 3'h7;

    // unit_control fields
    localparam int CTL_ENABLE_BIT = 7;
    localparam int CTL_OUTPUT_LEVEL_BIT = 5;
    localparam int CTL_ALIGN_BIT = 4;
    localparam int CTL_MODE_LSB = 0;

    // timer_control fields
    localparam int TCN_PIN_DRIVE_BIT = 7;
    localparam int TCN_TIMER_ON_BIT = 2;
    localparam int TCN_PRESCALE_LSB = 0;

    // status fields
    localparam int STA_EVENT_BIT = 0;
    localparam int STA_RES_LSB = 4;

    // reset values
    localparam logic [7:0] RST_UNIT_CONTROL = 8'h00;
    localparam logic [3:0] RST_CAPTURE_SOURCE = 4'h0;
    localparam logic [7:0] RST_DUTY_LOW = 8'h00;
    localparam logic [7:0] RST_DUTY_HIGH = 8'h00;
    localparam logic [7:0] RST_PERIOD_LIMIT = 8'hFF;
    localparam logic [7:0] RST_TIMER_CONTROL = 8'h00;

    // prescale codes and the last prescaler count of each
    localparam logic [1:0] PRE_1 = 2'h0;
    localparam logic [1:0] PRE_4 = 2'h1;
    localparam logic [1:0] PRE_16 = 2'h2;
    localparam logic [1:0] PRE_64 = 2'h3;
    localparam logic [5:0] PRE_LAST_1 = 6'h00;
    localparam logic [5:0] PRE_LAST_4 = 6'h03;
    localparam logic [5:0] PRE_LAST_16 = 6'h0F;
    localparam logic [5:0] PRE_LAST_64 = 6'h3F;
    localparam logic [1:0] PHASE_LAST = 2'h3;

    // unit modes
    typedef enum logic [3:0] {
        MODE_OFF = 4'b0000,
        MODE_CMP_TOGGLE_CLR = 4'b0001,
        MODE_CMP_TOGGLE = 4'b0010,
        MODE_CAP_FALL = 4'b0011,
        MODE_CAP_EDGE = 4'b0100,
        MODE_CAP_RISE = 4'b0101,
        MODE_CAP_RISE4 = 4'b0110,
        MODE_CAP_RISE16 = 4'b0111,
        MODE_CMP_SET = 4'b1000,
        MODE_CMP_CLEAR = 4'b1001,
        MODE_CMP_PULSE = 4'b1010,
        MODE_CMP_PULSE_CLR = 4'b1011,
        MODE_RSV_C = 4'b1100,
        MODE_RSV_D = 4'b1101,
        MODE_RSV_E = 4'b1110,
        MODE_PWM = 4'b1111
    } cpw_mode_t;

endpackage

// file: logic/cpw_pwm.sv
// top of the pwm unit: register port, timer, duty compare and pin drive
//
// How it works
// - duty held double buffered, no glitches
// - time base is timer count plus two bits
// - 1:1 prescale uses clock phase, else prescaler
// - time base equal to duty clears pin
// - resolution is log2 of 4(limit+1)
// - duty beyond period leaves pin unchanged
// - sleep freezes timer and module, pin held
// - after sleep timer resumes from held count
// - output frequency follows system clock
// - reset makes pin input, registers reset
// - period wrap clears timer, sets pin unless duty is zero, loads
// - duty writes take effect after period match
// - alignment bit selects right or left layout
// - capture select upper nibble reads zero
`timescale 1ns/1ps
module cpw_pwm (
    // clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // register port
    input wire logic [2:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    // power state
    input wire logic SLEEP,
    // waveform pin
    output logic WAVE_OUT,
    output logic WAVE_OE,
    // unit event
    output logic UNIT_EVENT
);

    // duty value from the register pair under the alignment bit
    function automatic logic [9:0] duty_of(
        input logic fmt,
        input logic [7:0] hi,
        input logic [7:0] lo
    );
        begin
            if (fmt) begin
                duty_of = {hi, lo[7:6]};
            end else begin
                duty_of = {hi[1:0], lo};
            end
        end
    endfunction

    // whole bits of resolution for a period limit
    function automatic logic [3:0] res_bits(input logic [7:0] lim);
        logic [8:0] n;
        logic [3:0] r;
        begin
            n = {1'b0, lim} + 9'h001;
            r = 4'h2;
            for (int i = 1; i < 9; i++) begin
                if (n >= (9'h001 << i)) begin
                    r = 4'(i + 2);
                end
            end
            res_bits = r;
        end
    endfunction

    // register state
    logic enable_q;
    logic align_q;
    cpw_pkg::cpw_mode_t mode_q;
    logic [3:0] cts_q;
    logic [7:0] duty_low_q;
    logic [7:0] duty_high_q;
    logic [7:0] period_limit_q;
    logic pin_drive_q;
    logic timer_on_q;
    logic [1:0] prescale_q;
    logic event_flag_q;
    logic [7:0] rdata_q;

    // links to the sub-blocks
    logic [7:0] period_timer_count;
    logic level;
    logic clear_event;
    cpw_tb_if tbus ();

    // write decode
    wire wr_ctl = WR && (ADDR == cpw_pkg::OFS_UNIT_CONTROL);
    wire wr_cts = WR && (ADDR == cpw_pkg::OFS_CAPTURE_SOURCE_SELECT);
    wire wr_dlo = WR && (ADDR == cpw_pkg::OFS_DUTY_LOW);
    wire wr_dhi = WR && (ADDR == cpw_pkg::OFS_DUTY_HIGH);
    wire wr_lim = WR && (ADDR == cpw_pkg::OFS_PERIOD_LIMIT);
    wire wr_tcn = WR && (ADDR == cpw_pkg::OFS_TIMER_CONTROL);
    wire wr_sta = WR && (ADDR == cpw_pkg::OFS_STATUS);

    // operating conditions
    wire is_pwm = (mode_q == cpw_pkg::MODE_PWM);
    wire active = enable_q && is_pwm;
    wire timer_run = timer_on_q && enable_q;
    wire [9:0] duty_value = duty_of(align_q, duty_high_q, duty_low_q);
    wire unit_event = clear_event;
    wire [3:0] resolution = res_bits(period_limit_q);

    // read views of each register
    wire [7:0] rd_ctl = {
        enable_q, 1'b0, level, align_q, mode_q
    };
    wire [7:0] rd_cts = {4'h0, cts_q};
    wire [7:0] rd_tcn = {
        pin_drive_q, 4'h0, timer_on_q, prescale_q
    };
    wire [7:0] rd_sta = {resolution, 3'h0, event_flag_q};
    wire [7:0] rd_mux =
        (ADDR == cpw_pkg::OFS_UNIT_CONTROL) ? rd_ctl :
        (ADDR == cpw_pkg::OFS_CAPTURE_SOURCE_SELECT) ? rd_cts :
        (ADDR == cpw_pkg::OFS_DUTY_LOW) ? duty_low_q :
        (ADDR == cpw_pkg::OFS_DUTY_HIGH) ? duty_high_q :
        (ADDR == cpw_pkg::OFS_PERIOD_LIMIT) ? period_limit_q :
        (ADDR == cpw_pkg::OFS_TIMER_CONTROL) ? rd_tcn :
        (ADDR == cpw_pkg::OFS_TIMER_COUNT) ? period_timer_count :
        rd_sta;

    // unit control
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            enable_q <= cpw_pkg::RST_UNIT_CONTROL[cpw_pkg::CTL_ENABLE_BIT];
            align_q <= cpw_pkg::RST_UNIT_CONTROL[cpw_pkg::CTL_ALIGN_BIT];
            mode_q <= cpw_pkg::MODE_OFF;
        end else if (wr_ctl) begin
            enable_q <= WDATA[cpw_pkg::CTL_ENABLE_BIT];
            align_q <= WDATA[cpw_pkg::CTL_ALIGN_BIT];
            mode_q <= cpw_pkg::cpw_mode_t'(WDATA[3:0]);
        end
    end

    // capture source select, low nibble only
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            cts_q <= cpw_pkg::RST_CAPTURE_SOURCE;
        end else if (wr_cts) begin
            cts_q <= WDATA[3:0];
        end
    end

    // duty register pair, writable at any time
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            duty_low_q <= cpw_pkg::RST_DUTY_LOW;
        end else if (wr_dlo) begin
            duty_low_q <= WDATA;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            duty_high_q <= cpw_pkg::RST_DUTY_HIGH;
        end else if (wr_dhi) begin
            duty_high_q <= WDATA;
        end
    end

    // period limit
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            period_limit_q <= cpw_pkg::RST_PERIOD_LIMIT;
        end else if (wr_lim) begin
            period_limit_q <= WDATA;
        end
    end

    // timer control and pin direction
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            pin_drive_q <= 1'b0;
            timer_on_q <= 1'b0;
            prescale_q <= cpw_pkg::PRE_1;
        end else if (wr_tcn) begin
            pin_drive_q <= WDATA[cpw_pkg::TCN_PIN_DRIVE_BIT];
            timer_on_q <= WDATA[cpw_pkg::TCN_TIMER_ON_BIT];
            prescale_q <= WDATA[1:0];
        end
    end

    // event flag: set wins over a write-one clear
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            event_flag_q <= 1'b0;
        end else if (unit_event) begin
            event_flag_q <= 1'b1;
        end else if (wr_sta && WDATA[cpw_pkg::STA_EVENT_BIT]) begin
            event_flag_q <= 1'b0;
        end
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            rdata_q <= 8'h00;
        end else if (RD) begin
            rdata_q <= rd_mux;
        end else begin
            rdata_q <= 8'h00;
        end
    end

    cpw_timebase u_timebase (
        .clk(CLK),
        .rst_n(RST_N),
        .sleep(SLEEP),
        .timer_on(timer_run),
        .prescale(prescale_q),
        .period_limit(period_limit_q),
        .period_timer_count(period_timer_count),
        .tb(tbus.src)
    );

    cpw_duty u_duty (
        .clk(CLK),
        .rst_n(RST_N),
        .active(active),
        .sleep(SLEEP),
        .duty_value(duty_value),
        .tb(tbus.dst),
        .level(level),
        .clear_event(clear_event)
    );

    assign RDATA = rdata_q;
    assign WAVE_OUT = level;
    assign WAVE_OE = pin_drive_q;
    assign UNIT_EVENT = unit_event;
endmodule

// file: logic/cpw_tb_if.sv
// interface: time base and period start from the timer to the duty comparator
`timescale 1ns/1ps
interface cpw_tb_if;
    logic [9:0] time_base;
    logic period_start;

    modport src (
        output time_base,
        output period_start
    );
    modport dst (
        input time_base,
        input period_start
    );
endinterface

// file: logic/cpw_timebase.sv
// period timer with prescaler and 10-bit time base
`timescale 1ns/1ps
module cpw_timebase (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // control
    input wire logic sleep,
    input wire logic timer_on,
    input wire logic [1:0] prescale,
    input wire logic [7:0] period_limit,
    // state
    output logic [7:0] period_timer_count,
    cpw_tb_if.src tb
);
    logic [1:0] phase_q;
    logic [5:0] pre_q;
    logic [7:0] count_q;
    logic start_q;

    wire quarter = timer_on && !sleep && (phase_q == cpw_pkg::PHASE_LAST);
    wire [5:0] pre_last =
        (prescale == cpw_pkg::PRE_1) ? cpw_pkg::PRE_LAST_1 :
        (prescale == cpw_pkg::PRE_4) ? cpw_pkg::PRE_LAST_4 :
        (prescale == cpw_pkg::PRE_16) ? cpw_pkg::PRE_LAST_16 :
        cpw_pkg::PRE_LAST_64;
    wire tick = quarter && (pre_q == pre_last);
    wire wrap = tick && (count_q == period_limit);
    // low bits: clock phase at 1:1, else the prescaler position
    wire [1:0] low_bits =
        (prescale == cpw_pkg::PRE_1) ? phase_q :
        (prescale == cpw_pkg::PRE_4) ? pre_q[1:0] :
        (prescale == cpw_pkg::PRE_16) ? pre_q[3:2] :
        pre_q[5:4];

    // phase follows the system clock, so the period scales with it
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            phase_q <= 2'h0;
        end else if (!sleep) begin
            phase_q <= phase_q + 2'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pre_q <= 6'h00;
        end else if (tick) begin
            pre_q <= 6'h00;
        end else if (quarter) begin
            pre_q <= pre_q + 6'h01;
        end
    end

    // count holds through sleep and resumes where it stopped
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            count_q <= 8'h00;
        end else if (wrap) begin
            count_q <= 8'h00;
        end else if (tick) begin
            count_q <= count_q + 8'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            start_q <= 1'b0;
        end else if (!sleep) begin
            start_q <= wrap;
        end
    end

    assign tb.time_base = {count_q, low_bits};
    assign tb.period_start = start_q;
    assign period_timer_count = count_q;
endmodule

// file: verif/cpw_load_model.sv
// load model: resolves the pin and times its high phase and period
`timescale 1ns/1ps
module cpw_load_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // pin drive
    input wire logic wave_out,
    input wire logic wave_oe,
    // measurements
    output logic pin,
    output logic [15:0] high_len,
    output logic [15:0] period_len,
    output logic [15:0] rises
);
    logic pin_q;
    logic [15:0] cnt_q;
    logic [15:0] hcnt_q;
    wire logic rise;
    // undriven pin is held low by the pull-down of the load
    assign pin = wave_oe ? wave_out : 1'b0;
    assign rise = pin && !pin_q;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pin_q <= 1'b0;
            cnt_q <= 16'h0000;
            hcnt_q <= 16'h0000;
            high_len <= 16'h0000;
            period_len <= 16'h0000;
            rises <= 16'h0000;
        end else begin
            pin_q <= pin;
            cnt_q <= rise ? 16'h0001 : cnt_q + 16'h0001;
            hcnt_q <= rise ? 16'h0001 : hcnt_q + {15'h0000, pin};
            if (rise) begin
                period_len <= cnt_q;
                high_len <= hcnt_q;
                rises <= rises + 16'h0001;
            end
        end
    end
endmodule

// file: verif/cpw_pwm_monitor.sv
// checker: pin, event and read-back relations of the pwm unit
`timescale 1ns/1ps
module cpw_pwm_monitor (
    // clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // register port
    input wire logic [2:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [7:0] RDATA,
    // pin and event
    input wire logic SLEEP,
    input wire logic WAVE_OUT,
    input wire logic WAVE_OE,
    input wire logic UNIT_EVENT
);
    wire logic ctl_wr;
    wire logic tcn_wr;
    wire logic ctl_rd;
    wire logic cap_rd;
    assign ctl_wr = WR && (ADDR == cpw_pkg::OFS_UNIT_CONTROL);
    assign tcn_wr = WR && (ADDR == cpw_pkg::OFS_TIMER_CONTROL);
    assign ctl_rd = RD && (ADDR == cpw_pkg::OFS_UNIT_CONTROL);
    assign cap_rd = RD && (ADDR == cpw_pkg::OFS_CAPTURE_SOURCE_SELECT);
    // shadow duty pair: a period start with zero duty drops the pin
    logic [7:0] lo_q;
    logic [7:0] hi_q;
    logic fmt_q;
    wire logic duty_zero;
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            lo_q <= cpw_pkg::RST_DUTY_LOW;
            hi_q <= cpw_pkg::RST_DUTY_HIGH;
            fmt_q <= cpw_pkg::RST_UNIT_CONTROL[cpw_pkg::CTL_ALIGN_BIT];
        end else begin
            if (WR && (ADDR == cpw_pkg::OFS_DUTY_LOW)) begin
                lo_q <= WDATA;
            end
            if (WR && (ADDR == cpw_pkg::OFS_DUTY_HIGH)) begin
                hi_q <= WDATA;
            end
            if (ctl_wr) begin
                fmt_q <= WDATA[cpw_pkg::CTL_ALIGN_BIT];
            end
        end
    end
    assign duty_zero = fmt_q ? (hi_q == 8'h00 && lo_q[7:6] == 2'h0)
        : (hi_q[1:0] == 2'h0 && lo_q == 8'h00);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_N);
    sequence s_match;
        UNIT_EVENT && !SLEEP;
    endsequence
    sequence s_pin_clear;
        WAVE_OUT ##1 !WAVE_OUT;
    endsequence
    property p_match_clears;
        s_match |-> s_pin_clear;
    endproperty
    a_match_clears: assert property (p_match_clears)
        else $error("match did not clear the pin");
    property p_event_pulse;
        s_match |=> !UNIT_EVENT;
    endproperty
    a_event_pulse: assert property (p_event_pulse)
        else $error("event longer than one cycle");
    property p_sleep_hold;
        $past(SLEEP) && $past(RST_N) |-> $stable(WAVE_OUT);
    endproperty
    a_sleep_hold: assert property (p_sleep_hold)
        else $error("pin moved during sleep");
    property p_reset_state;
        !$past(RST_N) |-> !WAVE_OUT && !WAVE_OE && !UNIT_EVENT
            && RDATA == 8'h00;
    endproperty
    a_reset_state: assert property (p_reset_state)
        else $error("outputs not at reset state");
    property p_fall_cause;
        $fell(WAVE_OUT) |-> $past(UNIT_EVENT) || $past(ctl_wr)
            || $past(ctl_wr, 2) || $past(duty_zero);
    endproperty
    a_fall_cause: assert property (p_fall_cause)
        else $error("pin fell without a match");
    property p_oe_cause;
        $changed(WAVE_OE) |-> $past(tcn_wr) || $past(tcn_wr, 2);
    endproperty
    a_oe_cause: assert property (p_oe_cause)
        else $error("pin direction changed without a write");
    property p_cap_read;
        $past(cap_rd) |-> RDATA[7:4] == 4'h0;
    endproperty
    a_cap_read: assert property (p_cap_read)
        else $error("capture select upper bits not zero");
    property p_ctl_read;
        $past(ctl_rd) |-> RDATA[6] == 1'b0 && RDATA[5] == $past(WAVE_OUT);
    endproperty
    a_ctl_read: assert property (p_ctl_read)
        else $error("control read does not show pin level");
    c_match: cover property (s_match);
endmodule

bind cpw_pwm cpw_pwm_monitor u_mon (.CLK(CLK), .RST_N(RST_N),
    .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .SLEEP(SLEEP), .WAVE_OUT(WAVE_OUT), .WAVE_OE(WAVE_OE),
    .UNIT_EVENT(UNIT_EVENT));

// file: verif/cpw_pwm_test.sv
// testbench: register port tasks and pwm waveform scenarios
`timescale 1ns/1ps
module cpw_pwm_test;
    logic CLK = 1'b0;
    logic RST_N = 1'b0;
    logic [2:0] ADDR = 3'h0;
    logic [7:0] WDATA = 8'h00;
    logic WR = 1'b0;
    logic RD = 1'b0;
    logic SLEEP = 1'b0;
    logic [7:0] RDATA;
    logic WAVE_OUT;
    logic WAVE_OE;
    logic UNIT_EVENT;
    logic pin;
    logic [15:0] high_len;
    logic [15:0] period_len;
    logic [15:0] rises;
    logic [7:0] rv;
    logic [7:0] held;
    int bad_count = 0;
    int samples_checked = 0;
    int m;
    always #2.5 CLK = ~CLK;
    cpw_pwm dut (.CLK(CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA),
        .WR(WR), .RD(RD), .RDATA(RDATA), .SLEEP(SLEEP),
        .WAVE_OUT(WAVE_OUT), .WAVE_OE(WAVE_OE), .UNIT_EVENT(UNIT_EVENT));
    cpw_load_model load (.clk(CLK), .rst_n(RST_N), .wave_out(WAVE_OUT),
        .wave_oe(WAVE_OE), .pin(pin), .high_len(high_len),
        .period_len(period_len), .rises(rises));
    task print_verdict;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task check(input string name, input logic [15:0] e, input logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", name, e, g);
        end
    endtask
    task wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge CLK);
        WR <= 1'b1;
        ADDR <= a;
        WDATA <= d;
        @(posedge CLK);
        WR <= 1'b0;
    endtask
    task rd(input logic [2:0] a);
        @(posedge CLK);
        RD <= 1'b1;
        ADDR <= a;
        @(posedge CLK);
        RD <= 1'b0;
        #1 rv = RDATA;
    endtask
    task rdc(input string name, input logic [2:0] a, input logic [7:0] e);
        rd(a);
        check(name, {8'h00, e}, {8'h00, rv});
    endtask
    task wait_rises(input logic [15:0] n);
        logic [15:0] start;
        int i;
        start = rises;
        for (i = 0; i < 4000 && (rises - start) < n; i++) @(posedge CLK);
        if ((rises - start) < n) begin
            check("rises", n, rises - start);
            print_verdict();
        end
    endtask
    task steady(input string name, input logic lvl, input int n);
        int i;
        int diff;
        diff = 0;
        for (i = 0; i < n; i++) begin
            @(posedge CLK);
            if (pin !== lvl) diff++;
        end
        check(name, 16'h0000, 16'(diff));
    endtask
    initial begin
        repeat (12) @(posedge CLK);
        RST_N <= 1'b1;
        rdc("ctl", 3'h0, cpw_pkg::RST_UNIT_CONTROL);
        rdc("cap", 3'h1, {4'h0, cpw_pkg::RST_CAPTURE_SOURCE});
        rdc("dlo", 3'h2, cpw_pkg::RST_DUTY_LOW);
        rdc("dhi", 3'h3, cpw_pkg::RST_DUTY_HIGH);
        rdc("lim", 3'h4, cpw_pkg::RST_PERIOD_LIMIT);
        rdc("tcn", 3'h5, cpw_pkg::RST_TIMER_CONTROL);
        wr(3'h6, 8'h55);
        rdc("count", 3'h6, 8'h00);
        wr(3'h1, 8'hFF);
        rdc("cap_wr", 3'h1, 8'h0F);
        for (m = 0; m < 16; m++) begin
            wr(3'h0, 8'(m));
            rdc("mode", 3'h0, 8'(m));
        end
        wr(3'h4, 8'h03);
        wr(3'h3, 8'h00);
        wr(3'h2, 8'h06);
        wr(3'h5, 8'h84);
        wr(3'h0, 8'h8F);
        wait_rises(3);
        check("period", 16'd16, period_len);
        check("high", 16'd6, high_len);
        rdc("status", 3'h7, 8'h41);
        wr(3'h4, 8'hFF);
        rd(3'h7);
        check("res_full", 16'hA, {12'h000, rv[7:4]});
        wr(3'h4, 8'h03);
        wr(3'h0, 8'h9F);
        wr(3'h3, 8'h02);
        wr(3'h2, 8'h40);
        wait_rises(3);
        check("left", 16'd9, high_len);
        wr(3'h3, 8'hFF);
        wr(3'h2, 8'hC0);
        repeat (40) @(posedge CLK);
        steady("over", 1'b1, 80);
        wr(3'h0, 8'h8F);
        wr(3'h3, 8'h00);
        wr(3'h2, 8'h00);
        repeat (40) @(posedge CLK);
        steady("zero", 1'b0, 80);
        wr(3'h2, 8'h06);
        wr(3'h5, 8'h85);
        wait_rises(3);
        check("period4", 16'd64, period_len);
        check("high4", 16'd24, high_len);
        @(posedge CLK);
        SLEEP <= 1'b1;
        rd(3'h6);
        held = rv;
        repeat (30) @(posedge CLK);
        rdc("sleep_cnt", 3'h6, held);
        @(posedge CLK);
        SLEEP <= 1'b0;
        wait_rises(2);
        check("wake", 16'd64, period_len);
        wr(3'h5, 8'h86);
        wait_rises(2);
        check("period16", 16'd256, period_len);
        check("high16", 16'd96, high_len);
        wr(3'h5, 8'h87);
        wait_rises(2);
        check("period64", 16'd1024, period_len);
        check("high64", 16'd384, high_len);
        wr(3'h0, 8'h0F);
        repeat (4) @(posedge CLK);
        steady("off", 1'b0, 40);
        rdc("ctl_off", 3'h0, 8'h0F);
        wr(3'h7, 8'h01);
        rdc("flag_clr", 3'h7, 8'h40);
        wr(3'h0, 8'h8F);
        repeat (30) @(posedge CLK);
        RST_N <= 1'b0;
        repeat (12) @(posedge CLK);
        RST_N <= 1'b1;
        check("oe", 16'h0000, {15'h0000, WAVE_OE});
        rdc("lim2", 3'h4, 8'hFF);
        rdc("ctl2", 3'h0, 8'h00);
        print_verdict();
    end
endmodule
